// ===== design/bru_cfg.svh
// Constants of the byte rotate unit: operation encodings and widths.
// Assumes it is included by bare name from the package and the modules.
`ifndef BRU_CFG_SVH
`define BRU_CFG_SVH

// Data width of the memory operand and working register
`define BRU_DATA_W      8
// Field positions in the operation code
`define BRU_OP_RIGHT    0
`define BRU_OP_FLAG     1
`define BRU_OP_WORK     2
// Operation encodings: {to working, through flag, right}
`define BRU_OP_L_MEM    3'h0
`define BRU_OP_R_MEM    3'h1
`define BRU_OP_LF_MEM   3'h2
`define BRU_OP_RF_MEM   3'h3
`define BRU_OP_L_WORK   3'h4
`define BRU_OP_R_WORK   3'h5
`define BRU_OP_LF_WORK  3'h6
`define BRU_OP_RF_WORK  3'h7
// Reset value of the data result register
`define BRU_DATA_RST    8'h00

`endif

// ===== design/bru_pkg.sv
// Types of the byte rotate unit: operation codes, sequencer states, decode helpers.
// Assumes bru_cfg.svh is on the include path.
`include "bru_cfg.svh"

package bru_pkg;

	// Operation selected by the core decoder
	typedef enum logic [2:0] {
		rotate_memory_left                 = `BRU_OP_L_MEM,
		rotate_memory_right                = `BRU_OP_R_MEM,
		rotate_memory_left_through_flag    = `BRU_OP_LF_MEM,
		rotate_memory_right_through_flag   = `BRU_OP_RF_MEM,
		rotate_left_to_working             = `BRU_OP_L_WORK,
		rotate_right_to_working            = `BRU_OP_R_WORK,
		rotate_left_via_flag_to_working    = `BRU_OP_LF_WORK,
		rotate_right_via_flag_to_working   = `BRU_OP_RF_WORK
	} bru_op_type;

	// Sequencer states, Gray coded
	typedef enum logic {
		BRU_IDLE  = 1'h0,
		BRU_WRITE = 1'h1
	} bru_state_type;

	// True when the result goes to the working register
	function automatic logic bru_to_working(input bru_op_type op);
		bru_to_working = op[`BRU_OP_WORK];
	endfunction

	// True when the carry flag takes part in the rotate
	function automatic logic bru_through_flag(input bru_op_type op);
		bru_through_flag = op[`BRU_OP_FLAG];
	endfunction

	// True for a right rotate
	function automatic logic bru_is_right(input bru_op_type op);
		bru_is_right = op[`BRU_OP_RIGHT];
	endfunction

endpackage

// ===== design/bru_rotator.sv
// Combinational one-bit rotator, eight or nine bits wide.
// Assumes its inputs are stable for the cycle in which the result is used.
`timescale 1ns/100ps
`include "bru_cfg.svh"

module bru_rotator #(
	parameter int WIDTH = `BRU_DATA_W
) (
	// Operand and flag
	input  wire logic [WIDTH-1:0] data_in,
	input  wire logic             carry_in,
	// Shape of the rotate
	input  wire logic             right,
	input  wire logic             through_flag,
	// Result
	output logic      [WIDTH-1:0] data_out,
	output logic                  carry_out
);

	logic fill_bit;

	// Bit shifted in: old carry for nine-bit rotates, else the bit falling out
	always_comb begin
		if (through_flag) begin
			fill_bit = carry_in;
		end else if (right) begin
			fill_bit = data_in[0];
		end else begin
			fill_bit = data_in[WIDTH-1];
		end
	end

	// Shift one place and take the escaping bit as the new carry
	always_comb begin
		if (right) begin
			data_out  = {fill_bit, data_in[WIDTH-1:1]};
			carry_out = data_in[0];
		end else begin
			data_out  = {data_in[WIDTH-2:0], fill_bit};
			carry_out = data_in[WIDTH-1];
		end
	end

endmodule

// ===== design/bru_top.sv
// Byte rotate datapath slice: one-bit rotates of a memory byte, result to memory
// or working register, optional rotate through the carry flag.
// Assumes the core decoder, memory and flag logic share ref_clk and reset.
`timescale 1ns/100ps
`include "bru_cfg.svh"

module bru_top
	import bru_pkg::*;
#(
	parameter int WIDTH = `BRU_DATA_W
) (
	// Clock and reset
	input  wire logic             ref_clk,
	input  wire logic             reset,
	// Operation request from the decoder
	input  wire logic             op_valid,
	input  wire bru_op_type       op_code,
	output logic                  op_ready,
	// Memory operand and carry flag as read by the core
	input  wire logic [WIDTH-1:0] mem_rdata,
	input  wire logic             carry_flag,
	// Memory write-back
	output logic      [WIDTH-1:0] mem_wdata,
	output logic                  mem_we,
	// Working register write
	output logic      [WIDTH-1:0] working_register_wdata,
	output logic                  working_register_we,
	// Carry flag write
	output logic                  carry_wdata,
	output logic                  carry_we
);

	bru_state_type    state_q;
	bru_state_type    state_d;
	logic [WIDTH-1:0] result_q;
	logic [WIDTH-1:0] result_d;
	logic             carry_q;
	logic             carry_d;
	logic             mem_we_q;
	logic             mem_we_d;
	logic             work_we_q;
	logic             work_we_d;
	logic             carry_we_q;
	logic             carry_we_d;
	logic [WIDTH-1:0] rot_data;
	logic             rot_carry;
	logic             accept;
	logic             op_to_work;
	logic             op_flag;
	logic             op_right;

	// Decoded once so the rotator and the strobe logic agree on the shape
	assign op_to_work = bru_to_working(op_code);
	assign op_flag    = bru_through_flag(op_code);
	assign op_right   = bru_is_right(op_code);

	// Rotated value is formed straight from the operand of this cycle
	bru_rotator #(
		.WIDTH        (WIDTH)
	) u_rotator (
		.data_in      (mem_rdata),
		.carry_in     (carry_flag),
		.right        (op_right),
		.through_flag (op_flag),
		.data_out     (rot_data),
		.carry_out    (rot_carry)
	);

	// One cycle of write strobes follows each taken operation; the busy cycle
	// lets the core commit the write before the next operand is read
	assign op_ready = (state_q == BRU_IDLE);
	assign accept   = op_valid && op_ready;

	// Next state and next strobes of the sequencer
	always_comb begin
		state_d    = state_q;
		mem_we_d   = 1'h0;
		work_we_d  = 1'h0;
		carry_we_d = 1'h0;
		case (state_q)
			BRU_IDLE: begin
				if (accept) begin
					state_d    = BRU_WRITE;
					mem_we_d   = !op_to_work;
					work_we_d  = op_to_work;
					carry_we_d = op_flag;
				end
			end
			BRU_WRITE: begin
				state_d = BRU_IDLE;
			end
			default: begin
				state_d = BRU_IDLE;
			end
		endcase
	end

	// Sequencer registers only
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			state_q    <= BRU_IDLE;
			mem_we_q   <= 1'h0;
			work_we_q  <= 1'h0;
			carry_we_q <= 1'h0;
		end else begin
			state_q    <= state_d;
			mem_we_q   <= mem_we_d;
			work_we_q  <= work_we_d;
			carry_we_q <= carry_we_d;
		end
	end

	// Next result and carry: loaded only on a taken request, so the outputs keep
	// the last result while the core commits it and until the next operation
	always_comb begin
		result_d = result_q;
		carry_d  = carry_q;
		if (accept) begin
			result_d = rot_data;
			carry_d  = rot_carry;
		end
	end

	// Result registers only
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			result_q <= WIDTH'(`BRU_DATA_RST);
			carry_q  <= 1'h0;
		end else begin
			result_q <= result_d;
			carry_q  <= carry_d;
		end
	end

	// Both destinations see the same result; only the strobe picks one
	assign mem_wdata              = result_q;
	assign mem_we                 = mem_we_q;
	assign working_register_wdata = result_q;
	assign working_register_we    = work_we_q;
	assign carry_wdata            = carry_q;
	assign carry_we               = carry_we_q;

	// Checks of the outputs against the operand taken one cycle earlier.
	// They sample at the clock edge, so the operand must stand for the whole
	// cycle in which the request is taken; a late operand shows up here first.
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (reset);

	sequence take_s(bru_op_type op);
		op_valid && op_ready && op_code == op;
	endsequence

	sequence mem_only_s;
		mem_we && !working_register_we;
	endsequence

	sequence work_only_s;
		working_register_we && !mem_we;
	endsequence

	// Busy for exactly one cycle, then ready again
	sequence busy_s;
		!op_ready ##1 op_ready;
	endsequence

	left_flag_mem_a : assert property (take_s(rotate_memory_left_through_flag) |=>
			mem_only_s ##0
			(mem_wdata == {$past(mem_rdata[WIDTH-2:0]), $past(carry_flag)})
			&& carry_we && carry_wdata == $past(mem_rdata[WIDTH-1]))
		else $error("left rotate through carry to memory wrong");

	left_flag_work_a : assert property (take_s(rotate_left_via_flag_to_working) |=>
			work_only_s ##0
			(working_register_wdata == {$past(mem_rdata[WIDTH-2:0]), $past(carry_flag)})
			&& carry_we && carry_wdata == $past(mem_rdata[WIDTH-1]))
		else $error("left rotate through carry to working register wrong");

	right_mem_a : assert property (take_s(rotate_memory_right) |=>
			mem_only_s ##0
			(mem_wdata == {$past(mem_rdata[0]), $past(mem_rdata[WIDTH-1:1])}) && !carry_we)
		else $error("right rotate to memory wrong");

	right_work_a : assert property (take_s(rotate_right_to_working) |=>
			work_only_s ##0
			(working_register_wdata == {$past(mem_rdata[0]), $past(mem_rdata[WIDTH-1:1])})
			&& !carry_we)
		else $error("right rotate to working register wrong");

	right_flag_mem_a : assert property (take_s(rotate_memory_right_through_flag) |=>
			mem_only_s ##0
			(mem_wdata == {$past(carry_flag), $past(mem_rdata[WIDTH-1:1])})
			&& carry_we && carry_wdata == $past(mem_rdata[0]))
		else $error("right rotate through carry to memory wrong");

	right_flag_work_a : assert property (take_s(rotate_right_via_flag_to_working) |=>
			work_only_s ##0
			(working_register_wdata == {$past(carry_flag), $past(mem_rdata[WIDTH-1:1])})
			&& carry_we && carry_wdata == $past(mem_rdata[0]))
		else $error("right rotate through carry to working register wrong");

	left_mem_a : assert property (take_s(rotate_memory_left) |=>
			mem_only_s ##0
			(mem_wdata == {$past(mem_rdata[WIDTH-2:0]), $past(mem_rdata[WIDTH-1])}) && !carry_we)
		else $error("left rotate to memory wrong");

	left_work_a : assert property (take_s(rotate_left_to_working) |=>
			work_only_s ##0
			(working_register_wdata == {$past(mem_rdata[WIDTH-2:0]), $past(mem_rdata[WIDTH-1])})
			&& !carry_we)
		else $error("left rotate to working register wrong");

	busy_gap_a : assert property (accept |=> busy_s)
		else $error("ready did not drop for exactly one cycle after a taken operation");

	result_hold_a : assert property (!accept |=> $stable(mem_wdata) && $stable(carry_wdata))
		else $error("result changed without a taken operation");

	refuse_busy_a : assert property ((op_valid && !op_ready) |=>
			op_ready && !mem_we && !working_register_we && !carry_we)
		else $error("request during busy cycle was not refused");

	strobe_single_a : assert property ((mem_we || working_register_we) |=>
			!mem_we && !working_register_we && !carry_we && op_ready)
		else $error("write strobe lasted more than one cycle");

	no_spurious_a : assert property (!(op_valid && op_ready) |=>
			!mem_we && !working_register_we && !carry_we)
		else $error("write strobe without a taken operation");

endmodule

// ===== test/tb_byte_rotate_unit.sv
// Self-checking bench of the byte rotate unit: each rotate kind, reset and refusal.
// Assumes the design package and modules are compiled before this file.
`timescale 1ns/100ps

`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin n_mismatch++; \
	$display("[FAIL] %s expected %h seen %h", nm, ex, gt); end end

module tb_byte_rotate_unit import bru_pkg::*;;

	logic       ref_clk = 1'h0;
	logic       reset = 1'h1;
	logic       op_valid = 1'h0;
	bru_op_type op_code = rotate_memory_left;
	logic       op_ready;
	logic [7:0] mem_rdata = 8'h00;
	logic       carry_flag = 1'h0;
	logic [7:0] mem_wdata;
	logic       mem_we;
	logic [7:0] working_register_wdata;
	logic       working_register_we;
	logic       carry_wdata;
	logic       carry_we;
	int         n_mismatch = 0;
	int         check_count = 0;

	// 25 MHz core clock
	always #20 ref_clk = ~ref_clk;

	bru_top uut (
		.ref_clk               (ref_clk),
		.reset                 (reset),
		.op_valid              (op_valid),
		.op_code               (op_code),
		.op_ready              (op_ready),
		.mem_rdata             (mem_rdata),
		.carry_flag            (carry_flag),
		.mem_wdata             (mem_wdata),
		.mem_we                (mem_we),
		.working_register_wdata(working_register_wdata),
		.working_register_we   (working_register_we),
		.carry_wdata           (carry_wdata),
		.carry_we              (carry_we)
	);

	// Prints counts and verdict; the only place the run ends
	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// One request held until taken; expectation worked out here from the rotate kind
	task automatic do_op(input bru_op_type op, input logic [7:0] d, input logic c);
		logic [7:0] ex_d;
		logic       ex_c;
		logic       to_w;
		logic       fl;
		int         i;
		to_w = op inside {rotate_left_to_working, rotate_right_to_working,
			rotate_left_via_flag_to_working, rotate_right_via_flag_to_working};
		fl = op inside {rotate_memory_left_through_flag, rotate_memory_right_through_flag,
			rotate_left_via_flag_to_working, rotate_right_via_flag_to_working};
		ex_c = c;
		case (op)
			rotate_memory_left, rotate_left_to_working: ex_d = {d[6:0], d[7]};
			rotate_memory_right, rotate_right_to_working: ex_d = {d[0], d[7:1]};
			rotate_memory_left_through_flag, rotate_left_via_flag_to_working: begin
				ex_d = {d[6:0], c};
				ex_c = d[7];
			end
			default: begin
				ex_d = {c, d[7:1]};
				ex_c = d[0];
			end
		endcase
		@(posedge ref_clk);
		op_valid <= 1'h1;
		op_code <= op;
		mem_rdata <= d;
		carry_flag <= c;
		#1;
		for (i = 0; i < 8 && op_ready !== 1'h1; i++) begin
			@(posedge ref_clk);
			#1;
		end
		if (op_ready !== 1'h1) begin
			n_mismatch++;
			give_verdict();
		end
		@(posedge ref_clk);
		op_valid <= 1'h0;
		mem_rdata <= ~d;        // Operand moves on; result must not follow it
		carry_flag <= ~c;
		#1;
		`CHK("op_ready busy", 1'h0, op_ready)
		`CHK("mem_we", ~to_w, mem_we)
		`CHK("working_register_we", to_w, working_register_we)
		`CHK("carry_we", fl, carry_we)
		if (to_w) begin
			`CHK("working_register_wdata", ex_d, working_register_wdata)
		end else begin
			`CHK("mem_wdata", ex_d, mem_wdata)
		end
		if (fl) begin
			`CHK("carry_wdata", ex_c, carry_wdata)
		end
		@(posedge ref_clk);
		#1;
		`CHK("strobes after", 3'h0, {mem_we, working_register_we, carry_we})
		`CHK("op_ready idle", 1'h1, op_ready)
	endtask

	task automatic sc_left_flag_mem();
		do_op(rotate_memory_left_through_flag, 8'h81, 1'h0);
		do_op(rotate_memory_left_through_flag, 8'h7E, 1'h1);
	endtask

	task automatic sc_left_flag_work();
		do_op(rotate_left_via_flag_to_working, 8'h80, 1'h1);
		do_op(rotate_left_via_flag_to_working, 8'h55, 1'h0);
	endtask

	task automatic sc_right_mem();
		do_op(rotate_memory_right, 8'h01, 1'h0);
		do_op(rotate_memory_right, 8'hA4, 1'h1);
	endtask

	task automatic sc_right_work();
		do_op(rotate_right_to_working, 8'h01, 1'h1);
		do_op(rotate_right_to_working, 8'hFE, 1'h0);
	endtask

	task automatic sc_right_flag_mem();
		do_op(rotate_memory_right_through_flag, 8'h01, 1'h0);
		do_op(rotate_memory_right_through_flag, 8'hFE, 1'h1);
	endtask

	task automatic sc_right_flag_work();
		do_op(rotate_right_via_flag_to_working, 8'h03, 1'h1);
		do_op(rotate_right_via_flag_to_working, 8'h80, 1'h0);
	endtask

	task automatic sc_left_mem();
		do_op(rotate_memory_left, 8'h80, 1'h1);
		do_op(rotate_memory_left, 8'h6A, 1'h0);
		do_op(rotate_left_to_working, 8'h81, 1'h0);
	endtask

	// Request held into the busy cycle is ignored, then taken once ready returns
	task automatic sc_refuse();
		@(posedge ref_clk);
		op_valid <= 1'h1;
		op_code <= rotate_memory_left;
		mem_rdata <= 8'h81;
		@(posedge ref_clk);
		op_code <= rotate_memory_right;
		mem_rdata <= 8'h01;
		#1;
		`CHK("first result", 8'h03, mem_wdata)
		@(posedge ref_clk);
		#1;
		`CHK("refused strobes", 3'h0, {mem_we, working_register_we, carry_we})
		@(posedge ref_clk);
		op_valid <= 1'h0;
		#1;
		`CHK("second result", 9'h180, {mem_we, mem_wdata})
		@(posedge ref_clk);
	endtask

	// Reset values while reset is high, then release on the next rising edge
	task automatic sc_reset();
		#1;
		`CHK("reset ready", 1'h1, op_ready)
		`CHK("reset strobes", 3'h0, {mem_we, working_register_we, carry_we})
		`CHK("reset data", 17'h00000, {mem_wdata, working_register_wdata, carry_wdata})
		@(posedge ref_clk);
		reset <= 1'h0;
	endtask

	// Reset in mid-run clears a non-zero result; the first request after it works
	task automatic sc_mid_reset();
		do_op(rotate_left_via_flag_to_working, 8'hFF, 1'h1);
		@(posedge ref_clk);
		reset <= 1'h1;
		@(posedge ref_clk);
		sc_reset();
		do_op(rotate_memory_right_through_flag, 8'h02, 1'h1);
	endtask

	initial begin
		repeat (11) @(posedge ref_clk);
		sc_reset();
		sc_left_flag_mem();
		sc_left_flag_work();
		sc_right_mem();
		sc_right_work();
		sc_right_flag_mem();
		sc_right_flag_work();
		sc_left_mem();
		sc_refuse();
		sc_mid_reset();
		give_verdict();
	end

endmodule
